// File: logic/arfw_pkg.sv
// Operation
// - right justify: bits 9:8 high, 7:0 low
// - right justify upper six: sign or zero
// - left justify: 9:2 high, 1:0 at 7:6
// - code scaled 10 single, 10 differential bits (two's complement)
// - compare each new result, set window flag
// - limits loaded as separate high/low bytes
// - inside or outside chosen by limit values
package arfw_pkg;
	localparam logic [7:0] OFF_RES_HI = 8'h00;
	localparam logic [7:0] OFF_RES_LO = 8'h04;
	localparam logic [7:0] OFF_GT_HI = 8'h08;
	localparam logic [7:0] OFF_GT_LO = 8'h0c;
	localparam logic [7:0] OFF_LT_HI = 8'h10;
	localparam logic [7:0] OFF_LT_LO = 8'h14;
	localparam logic [7:0] OFF_CTRL = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_MASK = 8'h20;
	localparam int CTRL_LJ_BIT = 0;
	localparam int CTRL_DIFF_BIT = 1;
	localparam int ST_WIN_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam logic [7:0] LIMIT_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int RES_W = 10;
endpackage : arfw_pkg

// File: logic/arfw_format.sv
`timescale 1ns/100ps
`default_nettype none
module arfw_format
	import arfw_pkg::*;
(
	// conversion result and format
	input wire logic [arfw_pkg::RES_W-1:0] result,
	input wire logic left_justify,
	input wire logic differential,
	// formatted word
	output logic [15:0] word
);
	always_comb begin
		if (left_justify) begin
			word = {result, 6'h00};
		end else begin
			// differential code is two's complement on 10 bits
			word = {{6{differential & result[9]}}, result};
		end
	end
endmodule : arfw_format
`default_nettype wire

// File: logic/arfw_window.sv
`timescale 1ns/100ps
`default_nettype none
module arfw_window
	import arfw_pkg::*;
(
	// formatted result and limits
	input wire logic [15:0] word,
	input wire logic [15:0] upper_limit,
	input wire logic [15:0] lower_limit,
	input wire logic signed_cmp,
	// comparison outcome
	output logic hit
);
	function automatic logic less(input logic [15:0] a, input logic [15:0] b, input logic s);
		less = s ? ($signed(a) < $signed(b)) : (a < b);
	endfunction : less
	logic lt_above_gt;
	logic below_lt;
	logic above_gt;
	always_comb begin
		lt_above_gt = less(upper_limit, lower_limit, signed_cmp);
		below_lt = less(word, lower_limit, signed_cmp);
		above_gt = less(upper_limit, word, signed_cmp);
		// limit order alone selects inside or outside detection
		if (lt_above_gt) begin
			hit = below_lt & above_gt;
		end else begin
			hit = below_lt | above_gt;
		end
	end
endmodule : arfw_window
`default_nettype wire

// File: logic/arfw_top.sv
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module arfw_top
	import arfw_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter core
	input wire logic [arfw_pkg::RES_W-1:0] conv_result,
	input wire logic conv_valid,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// interrupt
	output logic irq
);
	import arfw_pkg::*;

	logic [15:0] data_word;
	logic [15:0] upper_limit;
	logic [15:0] lower_limit;
	logic left_justify;
	logic differential;
	logic [1:0] status;
	logic [1:0] mask;
	logic have_result;
	logic [15:0] fmt_word;
	logic win_hit;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic rd_fire;
	logic rd_status;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic wr_err;
	logic [15:0] new_word;
	logic new_hit;

	arfw_format arfw_format_i (
		.result(conv_result),
		.left_justify(left_justify),
		.differential(differential),
		.word(fmt_word)
	);

	arfw_window arfw_window_i (
		.word(fmt_word),
		.upper_limit(upper_limit),
		.lower_limit(lower_limit),
		.signed_cmp(differential),
		.hit(win_hit)
	);

	// write channels accepted independently, in either order
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign wr_fire = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_comb begin
		case (aw_addr_q)
			OFF_RES_HI, OFF_RES_LO, OFF_GT_HI, OFF_GT_LO, OFF_LT_HI, OFF_LT_LO, OFF_CTRL, OFF_STATUS,
			OFF_MASK: begin
				wr_err = 1'b0;
			end
			default: begin
				wr_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// limit bytes are separate registers, each written through byte lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upper_limit <= {LIMIT_RST, LIMIT_RST};
			lower_limit <= {LIMIT_RST, LIMIT_RST};
			left_justify <= 1'b0;
			differential <= 1'b0;
			mask <= 2'b00;
		end else if (wr_fire && w_strb_q[0]) begin
			case (aw_addr_q)
				OFF_GT_HI: upper_limit[15:8] <= w_data_q[7:0];
				OFF_GT_LO: upper_limit[7:0] <= w_data_q[7:0];
				OFF_LT_HI: lower_limit[15:8] <= w_data_q[7:0];
				OFF_LT_LO: lower_limit[7:0] <= w_data_q[7:0];
				OFF_CTRL: begin
					left_justify <= w_data_q[CTRL_LJ_BIT];
					differential <= w_data_q[CTRL_DIFF_BIT];
				end
				OFF_MASK: mask <= w_data_q[1:0];
				default: begin
				end
			endcase
		end
	end

	// result bytes are software writable; a new conversion overwrites
	always_comb begin
		new_word = data_word;
		if (wr_fire && w_strb_q[0] && aw_addr_q == OFF_RES_HI) begin
			new_word[15:8] = w_data_q[7:0];
		end
		if (wr_fire && w_strb_q[0] && aw_addr_q == OFF_RES_LO) begin
			new_word[7:0] = w_data_q[7:0];
		end
		if (conv_valid) begin
			new_word = fmt_word;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_word <= 16'h0000;
			have_result <= 1'b0;
		end else begin
			data_word <= new_word;
			if (conv_valid) begin
				have_result <= 1'b1;
			end
		end
	end

	// compare every new result as it arrives
	assign new_hit = conv_valid && win_hit;

	// read answers one cycle after the address is taken
	assign arready = !rvalid;
	assign rd_fire = arvalid && arready;
	assign rd_status = rd_fire && araddr == OFF_STATUS;

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		case (araddr)
			OFF_RES_HI: next_rdata[7:0] = data_word[15:8];
			OFF_RES_LO: next_rdata[7:0] = data_word[7:0];
			OFF_GT_HI: next_rdata[7:0] = upper_limit[15:8];
			OFF_GT_LO: next_rdata[7:0] = upper_limit[7:0];
			OFF_LT_HI: next_rdata[7:0] = lower_limit[15:8];
			OFF_LT_LO: next_rdata[7:0] = lower_limit[7:0];
			OFF_CTRL: next_rdata[1:0] = {differential, left_justify};
			OFF_STATUS: next_rdata[1:0] = status;
			OFF_MASK: next_rdata[1:0] = mask;
			default: next_rerr = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// sticky status; a new event in the clearing read's cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= 2'b00;
		end else begin
			status[ST_WIN_BIT] <= new_hit || (status[ST_WIN_BIT] && !rd_status);
			status[ST_DONE_BIT] <= conv_valid || (status[ST_DONE_BIT] && !rd_status);
		end
	end

	assign irq = |(status & mask);

	a_right_format: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && !left_justify |=> data_word[9:0] == $past(conv_result)
		&& data_word[15:10] == {6{$past(differential) & $past(conv_result[9])}})
		else $error("right justified word wrong");
	a_sign_fill: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && !left_justify && !differential |=> data_word[15:10] == 6'h00)
		else $error("single ended fill not zero");
	a_left_format: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && left_justify |=> data_word == {$past(conv_result), 6'h00})
		else $error("left justified word wrong");
	a_diff_range: assert property (@(posedge aclk) disable iff (!aresetn)
		have_result && differential && !left_justify && $past(conv_valid)
		|-> $signed(data_word) >= -16'sd512 && $signed(data_word) <= 16'sd511)
		else $error("differential code out of range");
	a_window_set: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && win_hit |=> status[ST_WIN_BIT])
		else $error("window flag not set on hit");
	a_window_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		!conv_valid && (rd_status || !status[ST_WIN_BIT]) |=> !status[ST_WIN_BIT])
		else $error("window flag set without hit");
	a_limit_load: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && w_strb_q[0] && aw_addr_q == OFF_LT_LO |=> lower_limit[7:0] == $past(w_data_q[7:0]))
		else $error("limit byte not loaded");
	a_inside_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && !differential && lower_limit > upper_limit && fmt_word > upper_limit
		&& fmt_word < lower_limit |=> status[ST_WIN_BIT])
		else $error("inside window missed");
	a_outside_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && !differential && lower_limit <= upper_limit && fmt_word <= upper_limit
		&& fmt_word >= lower_limit |-> !win_hit)
		else $error("outside window false hit");
	// one answer per request, and flag upkeep around the status read
	a_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	a_rresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid && rready |=> !rvalid)
		else $error("read response repeated");
	a_done_set: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid |=> status[ST_DONE_BIT])
		else $error("done flag not set");
	a_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_status && !conv_valid |=> status == 2'b00)
		else $error("status not cleared by read");
	a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
		status[ST_WIN_BIT] && mask[ST_WIN_BIT] |-> irq)
		else $error("unmasked flag without interrupt");
	a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		status == 2'b00 |-> !irq)
		else $error("interrupt without flag");
	a_gt_hi_load: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && w_strb_q[0] && aw_addr_q == OFF_GT_HI |=> upper_limit[15:8] == $past(w_data_q[7:0]))
		else $error("upper high byte not loaded");
	a_gt_lo_load: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && w_strb_q[0] && aw_addr_q == OFF_GT_LO |=> upper_limit[7:0] == $past(w_data_q[7:0]))
		else $error("upper low byte not loaded");
	a_lt_hi_load: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && w_strb_q[0] && aw_addr_q == OFF_LT_HI |=> lower_limit[15:8] == $past(w_data_q[7:0]))
		else $error("lower high byte not loaded");
	a_strobe_off: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !w_strb_q[0] |=> $stable(upper_limit) && $stable(lower_limit))
		else $error("limit written without strobe");
	a_inside_diff: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && differential && $signed(lower_limit) > $signed(upper_limit)
		&& $signed(fmt_word) > $signed(upper_limit) && $signed(fmt_word) < $signed(lower_limit) |=> status[ST_WIN_BIT])
		else $error("signed inside window missed");
	a_outside_hit: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid && !differential && lower_limit <= upper_limit
		&& (fmt_word < lower_limit || fmt_word > upper_limit) |-> win_hit)
		else $error("outside window missed");
	a_result_take: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_valid |=> data_word == $past(fmt_word))
		else $error("new result not taken");
endmodule : arfw_top
`default_nettype wire

// File: verif/arfw_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module arfw_top_tb;
	import arfw_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [RES_W-1:0] conv_result = '0;
	logic conv_valid = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int num_errors = 0;
	int compares = 0;
	always #12.5 aclk = ~aclk;
	arfw_top arfw_top_i (.aclk(aclk), .aresetn(aresetn), .conv_result(conv_result), .conv_valid(conv_valid),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	// handshakes judged on pre-edge values; valid released after that edge, ready left high
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) begin
				`CHK(r, er)
				return;
			end
		end
		num_errors++;
		print_verdict();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'h0;
			if (tr) begin
				`CHK(d, ed)
				`CHK(r, er)
				return;
			end
		end
		num_errors++;
		print_verdict();
	endtask : rd
	task automatic conv(input logic [RES_W-1:0] c);
		conv_result <= c;
		conv_valid <= 1'h1;
		@(posedge aclk);
		conv_valid <= 1'h0;
		@(posedge aclk);
	endtask : conv
	task automatic t_reset();
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4), 32'h0, RESP_OKAY);
		end
		`CHK(irq, 1'h0)
	endtask : t_reset
	task automatic t_format();
		logic [9:0] cd [7] = '{10'h3ff, 10'h3ff, 10'h3ff, 10'h201, 10'h0ff, 10'h200, 10'h001};
		logic [1:0] cf [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h1};
		// words worked out by hand from the justify and sign rules
		logic [15:0] ew [7] = '{16'h03ff, 16'hffc0, 16'hffff, 16'h8040, 16'h00ff, 16'h0200, 16'h0040};
		for (int i = 0; i < 7; i++) begin
			wr(OFF_CTRL, {30'h0, cf[i]}, 4'h1, RESP_OKAY);
			conv(cd[i]);
			rd(OFF_RES_HI, {24'h0, ew[i][15:8]}, RESP_OKAY);
			rd(OFF_RES_LO, {24'h0, ew[i][7:0]}, RESP_OKAY);
		end
	endtask : t_format
	task automatic t_window();
		logic [1:0] cf [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1};
		logic [15:0] gt [9] = '{16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'hfff0, 16'hfff0, 16'h4000};
		logic [15:0] lt [9] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'h0010, 16'h0010, 16'h8000};
		logic [9:0] cd [9] = '{10'h050, 10'h150, 10'h201, 10'h200, 10'h150, 10'h100, 10'h3ff, 10'h100, 10'h180};
		// expected flag per case, from the limit order rule
		logic ef [9] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
		rd(OFF_STATUS, 32'h3, RESP_OKAY);
		for (int i = 0; i < 9; i++) begin
			wr(OFF_CTRL, {30'h0, cf[i]}, 4'h1, RESP_OKAY);
			wr(OFF_GT_HI, {24'h0, gt[i][15:8]}, 4'h1, RESP_OKAY);
			wr(OFF_GT_LO, {24'h0, gt[i][7:0]}, 4'h1, RESP_OKAY);
			wr(OFF_LT_HI, {24'h0, lt[i][15:8]}, 4'h1, RESP_OKAY);
			wr(OFF_LT_LO, {24'h0, lt[i][7:0]}, 4'h1, RESP_OKAY);
			conv(cd[i]);
			rd(OFF_STATUS, {30'h0, 1'h1, ef[i]}, RESP_OKAY);
			rd(OFF_STATUS, 32'h0, RESP_OKAY);
		end
	endtask : t_window
	task automatic t_irq();
		wr(OFF_MASK, 32'h1, 4'h1, RESP_OKAY);
		conv(10'h180);
		@(negedge aclk);
		`CHK(irq, 1'h1)
		@(posedge aclk);
		wr(OFF_MASK, 32'h0, 4'h1, RESP_OKAY);
		@(negedge aclk);
		`CHK(irq, 1'h0)
		@(posedge aclk);
		wr(OFF_MASK, 32'h1, 4'h1, RESP_OKAY);
		@(negedge aclk);
		`CHK(irq, 1'h1)
		@(posedge aclk);
		rd(OFF_STATUS, 32'h3, RESP_OKAY);
		@(negedge aclk);
		`CHK(irq, 1'h0)
		@(posedge aclk);
	endtask : t_irq
	task automatic t_bus();
		wr(OFF_GT_HI, 32'h123456a5, 4'h1, RESP_OKAY);
		rd(OFF_GT_HI, 32'ha5, RESP_OKAY);
		wr(OFF_GT_HI, 32'h5a, 4'h0, RESP_OKAY);
		rd(OFF_GT_HI, 32'ha5, RESP_OKAY);
		wr(OFF_RES_LO, 32'h3c, 4'h1, RESP_OKAY);
		rd(OFF_RES_LO, 32'h3c, RESP_OKAY);
		wr(8'h24, 32'hff, 4'hf, RESP_SLVERR);
		rd(8'h24, 32'h0, RESP_SLVERR);
	endtask : t_bus
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		t_format();
		t_window();
		t_irq();
		t_bus();
		print_verdict();
	end
endmodule : arfw_top_tb
`default_nettype wire
